/* File: verilog/wum_top.sv */
// write-uncorrectable command handler with per-sector mark lookup
`timescale 1ns/1ps
`include "wum_map.svh"
module wum_top
   import wum_pkg::*;
#(
   parameter int AW = 16,
   parameter int BLK_SECT = 8,
   parameter logic [31:0] CMD_LIMIT_CYC =
      32'(64'(`WUM_CMD_LIMIT_S) * 64'd1000000 * 64'(`WUM_CLK_MHZ))
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tf_valid,
   input wum_pkg::wum_tf_s tf,
   input wire logic hob,
   input wum_pkg::wum_sec_req_s sec_req,
   output logic ready,
   output logic media_req,
   output wum_pkg::wum_mop_e media_op,
   output logic [47:0] media_lba,
   input wire logic media_done,
   input wire logic media_err,
   input wire logic [7:0] media_err_bits,
   output logic done_r,
   output logic [7:0] command_status_flags_r,
   output logic [7:0] command_error_flags_r,
   output wum_pkg::wum_lba_out_s lba_out_r
);
   import wum_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE, ST_MARK, ST_RD_LOOK, ST_RD_GET, ST_RD_MEDIA,
      ST_WR_MEDIA, ST_WR_CLR, ST_WR_VFY, ST_FINISH
   } wum_state_e;

   localparam logic [48:0] BLK_MASK = 49'(BLK_SECT - 1);

   wum_state_e state_r, state_nxt;
   logic [48:0] cur_r, cur_nxt;
   logic [48:0] last_r, last_nxt;
   wum_mark_e kind_r, kind_nxt;
   logic [7:0] pend_r, pend_nxt;
   logic [47:0] fail_r, fail_nxt;
   logic [47:0] bad_lba_r, bad_lba_nxt;
   logic [31:0] tmo_r;
   logic [1:0] mem_rdata;
   wum_mark_e look_mark;

   // command decode and span of sectors to mark
   wire logic cmd_go = tf_valid && (tf.command == `WUM_OP_WRUNC);
   wire logic feat_pseudo = (tf.feature == `WUM_FEAT_PSEUDO);
   wire logic feat_flag = (tf.feature == `WUM_FEAT_FLAG);
   wire logic feat_bad = !feat_pseudo && !feat_flag;
   wire logic [15:0] cnt_raw = {tf.count_prev, tf.count_cur};
   wire logic [16:0] cmd_cnt =
      (cnt_raw == 16'h0000) ? `WUM_CNT_FULL : {1'b0, cnt_raw};
   wire logic [47:0] cmd_lba = wum_tf_lba(tf);
   wire logic [48:0] span_end =
      {1'b0, cmd_lba} + 49'(cmd_cnt) - 49'd1;
   // pseudo widens the span to whole physical blocks
   wire logic [48:0] mark_start =
      feat_pseudo ? ({1'b0, cmd_lba} & ~BLK_MASK) : {1'b0, cmd_lba};
   wire logic [48:0] mark_end =
      feat_pseudo ? (span_end | BLK_MASK) : span_end;
   wire logic cmd_range_bad = |(mark_end >> AW);
   wire logic sec_range_bad = |(sec_req.lba >> AW);
   wire logic tmo_hit = (state_r != ST_IDLE) && (state_r != ST_FINISH)
                        && (tmo_r == CMD_LIMIT_CYC - 32'd1);

   // mark store access
   wire logic mem_we = (state_r == ST_MARK) || (state_r == ST_WR_CLR);
   wire logic [AW-1:0] mem_addr = cur_r[AW-1:0];
   wire logic [1:0] mem_wdata =
      (state_r == ST_MARK) ? kind_r : WUM_MK_CLEAR;
   assign look_mark = wum_mark_e'(mem_rdata);

   // handshake and media request outputs
   assign ready = (state_r == ST_IDLE);
   assign media_req = (state_r == ST_RD_MEDIA) || (state_r == ST_WR_MEDIA)
                      || (state_r == ST_WR_VFY);
   assign media_op = (state_r == ST_WR_MEDIA) ? WUM_MOP_WRITE
                   : (state_r == ST_WR_VFY) ? WUM_MOP_VERIFY : WUM_MOP_READ;
   assign media_lba = cur_r[47:0];

   // mark memory, not cleared by reset
   wum_mark_mem #(.AW(AW), .DW(2)) u_marks (
      .clk(clk),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata_r(mem_rdata)
   );

   // sequencing of commands and sector accesses
   always_comb
   begin
      state_nxt = state_r;
      cur_nxt = cur_r;
      last_nxt = last_r;
      kind_nxt = kind_r;
      pend_nxt = pend_r;
      fail_nxt = fail_r;
      if (tmo_hit)
      begin
         pend_nxt[`WUM_ER_CCTO] = 1'b1;
         fail_nxt = cur_r[47:0];
         state_nxt = ST_FINISH;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               pend_nxt = `WUM_ERROR_RST;
               if (cmd_go)
               begin
                  cur_nxt = mark_start;
                  last_nxt = mark_end;
                  kind_nxt = feat_pseudo ? WUM_MK_PSEUDO : WUM_MK_FLAG;
                  fail_nxt = cmd_lba;
                  if (feat_bad || cmd_range_bad)
                  begin
                     pend_nxt[`WUM_ER_ABT] = 1'b1;
                     state_nxt = ST_FINISH;
                  end
                  else
                  begin
                     state_nxt = ST_MARK;
                  end
               end
               else if (sec_req.valid)
               begin
                  cur_nxt = {1'b0, sec_req.lba};
                  fail_nxt = sec_req.lba;
                  if (sec_range_bad)
                  begin
                     pend_nxt[`WUM_ER_IDN] = 1'b1;
                     state_nxt = ST_FINISH;
                  end
                  else
                  begin
                     state_nxt = sec_req.write ? ST_WR_MEDIA : ST_RD_LOOK;
                  end
               end
            end
            ST_MARK:
            begin
               cur_nxt = cur_r + 49'd1;
               if (cur_r == last_r)
               begin
                  state_nxt = ST_FINISH;
               end
            end
            ST_RD_LOOK:
               state_nxt = ST_RD_GET;
            ST_RD_GET:
            begin
               // flagged sectors fail at once, others go to media
               if (look_mark == WUM_MK_FLAG)
               begin
                  pend_nxt[`WUM_ER_UNC] = 1'b1;
                  state_nxt = ST_FINISH;
               end
               else
               begin
                  kind_nxt = look_mark;
                  state_nxt = ST_RD_MEDIA;
               end
            end
            ST_RD_MEDIA:
            begin
               if (media_done)
               begin
                  if (media_err)
                  begin
                     pend_nxt = pend_r | media_err_bits;
                  end
                  if (kind_r == WUM_MK_PSEUDO)
                  begin
                     pend_nxt[`WUM_ER_UNC] = 1'b1;
                  end
                  state_nxt = ST_FINISH;
               end
            end
            ST_WR_MEDIA:
            begin
               if (media_done)
               begin
                  if (media_err)
                  begin
                     pend_nxt = pend_r | media_err_bits;
                     state_nxt = ST_FINISH;
                  end
                  else
                  begin
                     state_nxt = ST_WR_CLR;
                  end
               end
            end
            ST_WR_CLR:
               state_nxt = ST_WR_VFY;
            ST_WR_VFY:
            begin
               if (media_done)
               begin
                  if (media_err)
                  begin
                     pend_nxt = pend_r | media_err_bits;
                  end
                  state_nxt = ST_FINISH;
               end
            end
            ST_FINISH:
               state_nxt = ST_IDLE;
         endcase
      end
   end

   // last failing address is kept until the next failure
   assign bad_lba_nxt = (state_r == ST_FINISH) && (pend_r != 8'h00)
                        ? fail_r : bad_lba_r;

   // state and working registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         cur_r <= '0;
         last_r <= '0;
         kind_r <= WUM_MK_CLEAR;
         pend_r <= `WUM_ERROR_RST;
         fail_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         cur_r <= cur_nxt;
         last_r <= last_nxt;
         kind_r <= kind_nxt;
         pend_r <= pend_nxt;
         fail_r <= fail_nxt;
      end
   end

   // completion time limit counter, restarts per request
   always_ff @(posedge clk)
   begin
      if (!rst_n || state_r == ST_IDLE || state_r == ST_FINISH)
      begin
         tmo_r <= '0;
      end
      else
      begin
         tmo_r <= tmo_r + 32'd1;
      end
   end

   // status, error, done and returned address
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         command_status_flags_r <= `WUM_STATUS_RST;
         command_error_flags_r <= `WUM_ERROR_RST;
         done_r <= 1'b0;
         bad_lba_r <= '0;
         lba_out_r <= '0;
      end
      else
      begin
         done_r <= (state_r == ST_FINISH);
         bad_lba_r <= bad_lba_nxt;
         lba_out_r <= wum_hob_sel(bad_lba_r, hob);
         if (state_r == ST_FINISH)
         begin
            command_error_flags_r <= pend_r;
            command_status_flags_r <= `WUM_STATUS_RST;
            command_status_flags_r[`WUM_ST_ERR] <= |pend_r;
         end
         else if (state_nxt != ST_IDLE && state_r == ST_IDLE)
         begin
            command_status_flags_r[`WUM_ST_BSY] <= 1'b1;
         end
      end
   end
endmodule // wum_top

/* File: verilog/wum_map.svh */
// constants for the write-uncorrectable marker block
`ifndef WUM_MAP_SVH
`define WUM_MAP_SVH
// opcode and feature codes
`define WUM_OP_WRUNC 8'h45
`define WUM_FEAT_PSEUDO 8'h55
`define WUM_FEAT_FLAG 8'haa
// status bit positions
`define WUM_ST_BSY 7
`define WUM_ST_RDY 6
`define WUM_ST_DSC 4
`define WUM_ST_ERR 0
// error bit positions
`define WUM_ER_UNC 6
`define WUM_ER_IDN 4
`define WUM_ER_ABT 2
`define WUM_ER_CCTO 0
// reset values
`define WUM_STATUS_RST 8'h50
`define WUM_ERROR_RST 8'h00
// zero count means the full 16-bit range
`define WUM_CNT_FULL 17'h10000
// clock rate and completion time limit
`define WUM_CLK_MHZ 100
`define WUM_CMD_LIMIT_S 30
`endif

/* File: verilog/wum_pkg.sv */
// types shared by the write-uncorrectable marker block
package wum_pkg;
   // per-sector mark
   typedef enum logic [1:0] {WUM_MK_CLEAR, WUM_MK_PSEUDO, WUM_MK_FLAG}
      wum_mark_e;
   // media engine operation
   typedef enum logic [1:0] {WUM_MOP_READ, WUM_MOP_WRITE, WUM_MOP_VERIFY}
      wum_mop_e;
   // task-file registers as written by the host
   typedef struct packed {
      logic [7:0] command;
      logic [7:0] feature;
      logic [7:0] count_prev;
      logic [7:0] count_cur;
      logic [7:0] ch_prev;
      logic [7:0] cl_prev;
      logic [7:0] sn_prev;
      logic [7:0] ch_cur;
      logic [7:0] cl_cur;
      logic [7:0] sn_cur;
   } wum_tf_s;
   // address bytes returned to the host
   typedef struct packed {
      logic [7:0] ch;
      logic [7:0] cl;
      logic [7:0] sn;
   } wum_lba_out_s;
   // sector read or write from the drive's sector engine
   typedef struct packed {
      logic valid;
      logic write;
      logic [47:0] lba;
   } wum_sec_req_s;
   // 48-bit address from the task file
   function automatic logic [47:0] wum_tf_lba(input wum_tf_s tf);
      return {tf.ch_prev, tf.cl_prev, tf.sn_prev,
              tf.ch_cur, tf.cl_cur, tf.sn_cur};
   endfunction
   // address bytes for the selected high-order-byte view
   function automatic wum_lba_out_s wum_hob_sel(input logic [47:0] lba,
                                               input logic hob);
      return hob ? {lba[47:40], lba[39:32], lba[31:24]}
                 : {lba[23:16], lba[15:8], lba[7:0]};
   endfunction
endpackage

/* File: verilog/wum_mark_mem.sv */
// per-sector mark store, registered read data
`timescale 1ns/1ps
module wum_mark_mem #(
   parameter int AW = 16,
   parameter int DW = 2
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata_r
);
   logic [DW-1:0] mem_r [0:(1<<AW)-1];

   // contents are never touched by reset, so marks outlive it
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem_r[addr] <= wdata;
      end
      rdata_r <= mem_r[addr];
   end
endmodule // wum_mark_mem

/* File: verif/wum_chk_assertions.sv */
// assertions on the ports of the marker block
`timescale 1ns/1ps
module wum_chk
   import wum_pkg::*;
#(
   parameter int AW = 16,
   parameter int BLK_SECT = 8,
   parameter logic [31:0] CMD_LIMIT_CYC = 32'd200
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tf_valid,
   input wum_pkg::wum_tf_s tf,
   input wum_pkg::wum_sec_req_s sec_req,
   input wire logic ready,
   input wire logic media_req,
   input wum_pkg::wum_mop_e media_op,
   input wire logic media_done,
   input wire logic done_r,
   input wire logic [7:0] command_status_flags_r,
   input wire logic [7:0] command_error_flags_r
);
   localparam int DN = BLK_SECT + 2;
   logic [31:0] bcnt_r;
   wire [7:0] st = command_status_flags_r;
   wire [7:0] er = command_error_flags_r;
   wire [47:0] lba = wum_tf_lba(tf);
   wire [15:0] cnt = {tf.count_prev, tf.count_cur};
   wire take = ready && tf_valid && tf.command == 8'h45;
   wire in_st = lba + 48'(BLK_SECT) <= (48'd1 << AW);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // busy run length
   always_ff @(posedge clk)
      bcnt_r <= (!rst_n || ready) ? 32'd0 : bcnt_r + 32'd1;
   sequence s_fin(logic [7:0] s, logic [7:0] e);
      done_r && st == s && er == e;
   endsequence
   a_bad_feat_abort: assert property (take && tf.feature != 8'h55 &&
      tf.feature != 8'haa |-> ##2 s_fin(8'h51, 8'h04))
      else $error("reserved feature not aborted");
   a_flag_one_done: assert property (take && tf.feature == 8'haa &&
      cnt == 16'h1 && in_st |-> ##3 s_fin(8'h50, 8'h00))
      else $error("single flag not done in time");
   a_pseudo_blk_span: assert property (take &&
      tf.feature == 8'h55 && cnt == 16'h1 && lba % BLK_SECT == 0 && in_st
      |-> ##DN s_fin(8'h50, 8'h00))
      else $error("pseudo span wrong");
   a_zero_count_full: assert property (take && AW < 16 &&
      cnt == 16'h0 |-> ##2 s_fin(8'h51, 8'h04))
      else $error("zero count not full range");
   a_other_op_quiet: assert property (ready && tf_valid &&
      tf.command != 8'h45 && !sec_req.valid |=> ready)
      else $error("foreign opcode taken");
   a_write_first: assert property (ready && !tf_valid &&
      sec_req.valid && sec_req.write && sec_req.lba < (48'd1 << AW)
      |=> media_req && media_op == WUM_MOP_WRITE)
      else $error("write not started");
   a_verify_done: assert property (media_req && media_done &&
      media_op == WUM_MOP_VERIFY |-> ##2 done_r)
      else $error("no completion after verify");
   a_read_done: assert property (media_req && media_done &&
      media_op == WUM_MOP_READ |-> ##2 done_r && st[0] == (er != 8'h0))
      else $error("read completion wrong");
   a_unc_sets_err: assert property (done_r && er[6] |-> st[0])
      else $error("uncorrectable without error status");
   a_busy_limit: assert property (bcnt_r <= CMD_LIMIT_CYC + 32'd8)
      else $error("busy beyond time limit");
endmodule // wum_chk
bind wum_top wum_chk #(.AW(AW), .BLK_SECT(BLK_SECT),
   .CMD_LIMIT_CYC(CMD_LIMIT_CYC)) u_chk (.*);

/* File: verif/wum_media.sv */
// media engine model answering media requests
`timescale 1ns/1ps
module wum_media (
   input wire logic clk,
   input wire logic media_req,
   input wire logic [15:0] lat,
   input wire logic inj_err,
   input wire logic [7:0] err_bits,
   output logic media_done,
   output logic media_err,
   output logic [7:0] media_err_bits
);
   logic [15:0] cnt_r;
   initial
   begin
      cnt_r = 16'h0;
      media_done = 1'b0;
      media_err = 1'b0;
      media_err_bits = 8'h00;
   end
   // answer after lat cycles, junk on error lines otherwise
   always @(posedge clk)
   begin
      media_done <= 1'b0;
      media_err <= ~media_err;
      media_err_bits <= ~media_err_bits;
      cnt_r <= 16'h0;
      if (media_req && !media_done && cnt_r == lat)
      begin
         media_done <= 1'b1;
         media_err <= inj_err;
         media_err_bits <= err_bits;
      end
      else if (media_req && !media_done)
         cnt_r <= cnt_r + 16'h1;
   end
endmodule // wum_media

/* File: verif/tb.sv */
// self-checking bench for the marker block
`timescale 1ns/1ps
module tb;
   import wum_pkg::*;
   localparam int AW = 8;
   localparam int BS = 8;
   logic clk, rst_n, tf_valid, hob, ready, media_req, done_r, tmo;
   logic media_done, media_err, inj_err;
   logic [7:0] media_err_bits, err_bits, st, er;
   logic [15:0] lat;
   logic [47:0] media_lba, mlba;
   logic [31:0] seed;
   wum_tf_s tf;
   wum_sec_req_s sec_req;
   wum_mop_e media_op;
   wum_lba_out_s lba_out_r;
   int miscompares, n_tests, nmed, mk[int];
   wum_top #(.AW(AW), .BLK_SECT(BS), .CMD_LIMIT_CYC(32'd200)) u_dut (
      .clk(clk), .rst_n(rst_n), .tf_valid(tf_valid), .tf(tf), .hob(hob),
      .sec_req(sec_req), .ready(ready), .media_req(media_req),
      .media_op(media_op), .media_lba(media_lba), .media_done(media_done),
      .media_err(media_err), .media_err_bits(media_err_bits),
      .done_r(done_r), .command_status_flags_r(st),
      .command_error_flags_r(er), .lba_out_r(lba_out_r));
   wum_media u_med (.clk(clk), .media_req(media_req), .lat(lat),
      .inj_err(inj_err), .err_bits(err_bits), .media_done(media_done),
      .media_err(media_err), .media_err_bits(media_err_bits));
   // clock and media activity count
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (media_req) nmed <= nmed + 1;
      if (media_req) mlba <= media_lba;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [47:0] s, input logic [47:0] e);
      n_tests++;
      if (s !== e)
      begin
         miscompares++;
         $display("wrong value t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic complete_run();
      $display("tests %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // cycles from the take edge to done_r
   task automatic wait_done(output int k);
      k = 0;
      do
      begin
         @(posedge clk);
         #1;
         tf_valid = 1'b0;
         sec_req.valid = 1'b0;
         k++;
      end
      while (done_r !== 1'b1 && k < 600);
      if (done_r !== 1'b1)
      begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic cmd(input logic [7:0] ft, input int lba, input int n);
      int k, a, b, ee, c;
      c = (n == 0) ? 65536 : n;
      a = (ft == 8'h55) ? lba / BS * BS : lba;
      b = (ft == 8'h55) ? (lba + c + BS - 1) / BS * BS : lba + c;
      ee = (ft != 8'h55 && ft != 8'haa) || b > 2 ** AW;
      @(posedge clk);
      #1;
      tf = '0;
      tf.command = 8'h45;
      tf.feature = ft;
      {tf.count_prev, tf.count_cur} = 16'(n);
      {tf.ch_cur, tf.cl_cur, tf.sn_cur} = 24'(lba);
      tf_valid = 1'b1;
      wait_done(k);
      chk(k, ee ? 2 : b - a + 2);
      chk(er, ee ? 8'h04 : 8'h00);
      chk(st, ee ? 8'h51 : 8'h50);
      for (int i = a; i < b && !ee; i++)
         mk[i] = (ft == 8'h55) ? 1 : 2;
   endtask
   task automatic sec(input logic wr, input logic [47:0] lba,
      input logic e, input logic [7:0] eb);
      int k, m, n0;
      logic [7:0] x;
      m = (lba >= 2 ** AW) ? 3 : mk.exists(lba) ? mk[lba] : 0;
      @(posedge clk);
      #1;
      inj_err = e;
      err_bits = eb;
      sec_req = '{1'b1, wr, lba};
      n0 = nmed;
      wait_done(k);
      inj_err = 1'b0;
      x = e ? eb : 8'h00;
      if (m == 3) x = 8'h10;
      else if (m == 2 && !wr) x = 8'h40;
      else if (m == 1 && !wr) x = x | 8'h40;
      if (tmo) x = 8'h01;
      if (wr && !e) mk[lba] = 0;
      chk(er, x);
      chk(st, {7'h28, x != 8'h00});
      if (m == 2 && !wr) chk(k, 4);
      if (m == 2 && !wr) chk(nmed - n0, 0);
      if (nmed != n0) chk(mlba, lba);
   endtask
   // main sequence
   initial
   begin
      rst_n = 1'b0;
      tf_valid = 1'b0;
      tf = '0;
      hob = 1'b0;
      sec_req = '0;
      lat = 16'd2;
      inj_err = 1'b0;
      err_bits = 8'h00;
      tmo = 1'b0;
      seed = 32'h2741;
      miscompares = 0;
      n_tests = 0;
      nmed = 0;
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 32; i++) sec(1, i, 0, 8'h00);
      cmd(8'haa, 5, 1);
      sec(0, 5, 0, 8'h00);
      sec(1, 5, 0, 8'h00);
      sec(0, 5, 0, 8'h00);
      cmd(8'h55, 8, 1);
      lat = 16'd9;
      sec(0, 15, 1, 8'h81);
      sec(0, 8, 0, 8'h00);
      lat = 16'd0;
      for (int i = 0; i < 6; i++) cmd(8'(8'h53 + i * 29), 0, 1);
      cmd(8'haa, 0, 0);
      cmd(8'haa, 0, 16'h0101);
      cmd(8'h55, 255, 2);
      cmd(8'haa, 255, 1);
      sec(0, 255, 0, 8'h00);
      cmd(8'haa, 3, 1);
      sec(1, 3, 1, 8'h84);
      sec(0, 3, 0, 8'h00);
      tf.command = 8'h20;
      tf_valid = 1'b1;
      @(posedge clk);
      #1;
      chk(ready, 1'b1);
      tf_valid = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(ready, 1'b1);
      tmo = 1'b1;
      lat = 16'd250;
      sec(0, 1, 0, 8'h00);
      tmo = 1'b0;
      sec(0, 48'h123456789abc, 0, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk(lba_out_r, 24'h789abc);
      hob = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(lba_out_r, 24'h123456);
      hob = 1'b0;
      // mid-run reset must leave the marks in place
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      sec(0, 3, 0, 8'h00);
      for (int i = 0; i < 40; i++)
      begin
         seed = lfsr(seed);
         lat = 16'(seed[3:0]);
         case (seed[5:4])
            2'd0: cmd(8'haa, seed[12:8] % 24, seed[14:13] + 1);
            2'd1: cmd(8'h55, seed[12:8] % 24, 1);
            default: sec(seed[4], seed[12:8], seed[15], seed[23:16] | 8'h80);
         endcase
      end
      complete_run();
   end
endmodule // tb
